/* File: src/data_map_pkg.sv */
/*
 * Constants, types and helpers for the core's internal data-memory map:
 * special-register offsets, reset values, status-word fields, request kinds
 * and the clock-rate figures for the core tick generator.
 * Assumes one 50 MHz system clock and a core sequencer that issues the
 * memory requests described by mem_req_s.
 */
// Functional notes
// RULE1: Core clock comes from a 16.78 MHz PLL through a programmable divider.
// RULE2: One machine cycle lasts exactly twelve core clock periods.
// RULE3: No external memory bus; all code comes from on-chip 8 kB memory.
// RULE4: Lower RAM, upper RAM, special registers, 640-byte array; upper RAM shares special addresses.
// RULE5: Lower RAM direct or indirect, upper RAM indirect only, special registers direct only.
// RULE6: Nonvolatile array is never directly addressed; only through its control registers.
// RULE7: Lowest 32 bytes form four banks of eight working registers.
// RULE8: Bytes 20H to 2FH are bit-addressable as bit addresses 00H to 7FH.
// RULE9: Stack may sit anywhere in internal RAM and grow to 256 bytes.
// RULE10: Stack pointer resets to 07H and increments before each push store.
// RULE11: Secondary register joins accumulator for multiply and divide, else scratch.
// RULE12: Data pointer is two bytes usable as one 16-bit value or separately.
// RULE13: Status word at D0H resets to 00H, bit-addressable, fixed flag layout.
// RULE14: Bank-select bits as value 0 to 3 choose the working-register bank.
// RULE15: Parity bit follows the accumulator; software writes to it do not last.
package data_map_pkg;

    // ==================================================================
    // Special-register offsets and reset values
    // ==================================================================
    localparam logic [7:0] SFR_STACK_TOP = 8'h81;
    localparam logic [7:0] SFR_DATA_LOW  = 8'h82;
    localparam logic [7:0] SFR_DATA_HIGH = 8'h83;
    localparam logic [7:0] SFR_STATUS    = 8'hd0;
    localparam logic [7:0] SFR_RESULT    = 8'he0;
    localparam logic [7:0] SFR_SECOND    = 8'hf0;

    localparam logic [7:0] STACK_TOP_RST = 8'h07;
    localparam logic [7:0] STATUS_RST    = 8'h00;
    localparam logic [7:0] REG_RST       = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam logic [7:0] SPECIAL_BASE  = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;

    // ==================================================================
    // Status-word field positions
    // ==================================================================
    localparam int CARRY_POS     = 7;
    localparam int HALF_POS      = 6;
    localparam int USER0_POS     = 5;
    localparam int BANK_HIGH_POS = 4;
    localparam int BANK_LOW_POS  = 3;
    localparam int OVERRUN_POS   = 2;
    localparam int USER1_POS     = 1;
    localparam int PARITY_POS    = 0;

    // ==================================================================
    // Clock figures
    // ==================================================================
    localparam logic [15:0] SYS_FREQ_KHZ     = 16'd50000;
    localparam logic [15:0] PLL_FREQ_KHZ     = 16'd16780;
    localparam logic [3:0]  CORE_PER_MACHINE = 4'd12;
    localparam int          DIV_SEL_W        = 3;
    localparam int          CODE_ADDR_W      = 13;

    // ==================================================================
    // Types
    // ==================================================================
    typedef enum logic [3:0] {
        K_DIRECT_RD   = 4'h0,
        K_DIRECT_WR   = 4'h1,
        K_INDIRECT_RD = 4'h2,
        K_INDIRECT_WR = 4'h3,
        K_REG_RD      = 4'h4,
        K_REG_WR      = 4'h5,
        K_BIT_RD      = 4'h6,
        K_BIT_WR      = 4'h7,
        K_PUSH        = 4'h8,
        K_POP         = 4'h9
    } req_kind_e;

    typedef enum logic {
        S_IDLE = 1'b0,
        S_READ = 1'b1
    } access_state_e;

    typedef struct packed {
        logic      valid;
        req_kind_e kind;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic        result_we;
        logic [7:0]  result;
        logic        second_we;
        logic [7:0]  second;
        logic        carry_we;
        logic        carry;
        logic        half_we;
        logic        half;
        logic        overrun_we;
        logic        overrun;
        logic        ptr_we;
        logic [15:0] ptr;
        logic        ptr_inc;
    } alu_upd_s;

    typedef struct packed {
        logic [7:0] result;
        logic [7:0] second;
        logic [7:0] stack_top;
        logic [7:0] ptr_high;
        logic [7:0] ptr_low;
        logic [7:0] status;
    } core_view_s;

    // Byte that holds a given bit address.
    function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
        if (bit_addr[7]) begin
            bit_byte = {bit_addr[7:3], 3'b000};
        end else begin
            bit_byte = BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
        end
    endfunction : bit_byte

    // RAM location of working register r in bank {hi,lo}.
    function automatic logic [7:0] reg_byte(input logic [1:0] bank, input logic [2:0] r);
        reg_byte = {3'b000, bank, r};
    endfunction : reg_byte

endpackage : data_map_pkg

/* File: src/data_ram256.sv */
/*
 * 256-byte internal data RAM with one write port and a registered read port.
 * Assumes the owner never writes and reads the same byte in one cycle when
 * it needs the new value; read data appear one edge after the address.
 */
`timescale 1ns/100ps
`default_nettype none
module data_ram256 (
    input  wire logic       i_clk,
    input  wire logic       i_we,
    input  wire logic [7:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_raddr,
    output var  logic [7:0] o_rdata
);
    logic [7:0] mem [256];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : data_ram256
`default_nettype wire

/* File: src/cpu_data_memory_map.sv */
/*
 * Internal data-memory map of the core: lower and upper RAM, working
 * register banks, bit area, stack, and the core special registers, plus
 * the core and machine-cycle tick generator.
 * Assumes the core sequencer issues one request at a time while o_ready
 * is high, and that other special registers live outside this block.
 */
`timescale 1ns/100ps
`default_nettype none
module cpu_data_memory_map (
    input  wire logic                                 i_clk,
    input  wire logic                                 i_rst,
    input  wire logic [data_map_pkg::DIV_SEL_W-1:0]   i_div_sel,
    input  wire data_map_pkg::mem_req_s               i_req,
    input  wire data_map_pkg::alu_upd_s               i_alu,
    output logic                                      o_ready,
    output logic                                      o_rvalid,
    output logic [7:0]                                o_rdata,
    output data_map_pkg::core_view_s                  o_view,
    output logic [data_map_pkg::CODE_ADDR_W-1:0]      o_code_ptr,
    output logic                                      o_core_tick,
    output logic                                      o_machine_tick
);
    import data_map_pkg::*;

    // ==================================================================
    // Core and machine-cycle ticks
    // ==================================================================
    // A phase accumulator gives an exact 16.78 MHz average from 50 MHz;
    // jitter of one system cycle per PLL tick is the price.
    logic [15:0] phase_q, phase_d;
    logic [6:0]  div_q, div_d;
    logic [3:0]  mach_q, mach_d;
    logic        core_tick_d, mach_tick_d;
    logic [16:0] phase_sum;
    logic [6:0]  div_last;

    always_comb begin
        phase_sum   = {1'b0, phase_q} + {1'b0, PLL_FREQ_KHZ};
        div_last    = 7'((8'h01 << i_div_sel) - 8'h01);
        phase_d     = phase_sum[15:0];
        div_d       = div_q;
        mach_d      = mach_q;
        core_tick_d = 1'b0;
        mach_tick_d = 1'b0;
        if (phase_sum >= {1'b0, SYS_FREQ_KHZ}) begin
            phase_d = 16'(phase_sum - {1'b0, SYS_FREQ_KHZ}); // RULE1
            if (div_q >= div_last) begin
                div_d       = 7'h00;
                core_tick_d = 1'b1; // RULE1
                if (mach_q == CORE_PER_MACHINE - 4'd1) begin
                    mach_d      = 4'h0;
                    mach_tick_d = 1'b1; // RULE2
                end else begin
                    mach_d = mach_q + 4'd1; // RULE2
                end
            end else begin
                div_d = div_q + 7'd1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_q        <= 16'h0000;
            div_q          <= 7'h00;
            mach_q         <= 4'h0;
            o_core_tick    <= 1'b0;
            o_machine_tick <= 1'b0;
        end else begin
            phase_q        <= phase_d;
            div_q          <= div_d;
            mach_q         <= mach_d;
            o_core_tick    <= core_tick_d;
            o_machine_tick <= mach_tick_d;
        end
    end

    // ==================================================================
    // Registers and access sequencing
    // ==================================================================
    access_state_e state_q, state_d;
    mem_req_s      req_q, req_d;
    logic [7:0]    result_q, result_d, second_q, second_d, top_q, top_d;
    logic [7:0]    phigh_q, phigh_d, plow_q, plow_d;
    logic [7:1]    status_q, status_d;
    logic [7:0]    rdata_d;
    logic          rvalid_d;
    logic          ram_we;
    logic [7:0]    ram_waddr, ram_wdata, ram_raddr, ram_rdata;
    logic          sfr_we;
    logic [7:0]    sfr_addr, sfr_wdata, byte_v, top_inc;
    logic [15:0]   ptr_v;
    logic [1:0]    bank;
    logic          take, from_ram;

    data_ram256 u_ram (
        .i_clk   (i_clk),
        .i_we    (ram_we),
        .i_waddr (ram_waddr),
        .i_wdata (ram_wdata),
        .i_raddr (ram_raddr),
        .o_rdata (ram_rdata)
    );

    // Special-register read; addresses not held here read as zero, which
    // includes anything that might be taken for the nonvolatile array.
    function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] res,
                                            input logic [7:0] sec, input logic [7:0] top,
                                            input logic [7:0] ph, input logic [7:0] pl,
                                            input logic [7:1] st);
        case (a)
            SFR_RESULT:    sfr_read = res;
            SFR_SECOND:    sfr_read = sec;
            SFR_STACK_TOP: sfr_read = top;
            SFR_DATA_HIGH: sfr_read = ph;
            SFR_DATA_LOW:  sfr_read = pl;
            SFR_STATUS:    sfr_read = {st, ^res};
            default:       sfr_read = UNMAPPED_READ; // RULE6
        endcase
    endfunction : sfr_read

    always_comb begin
        state_d   = state_q;
        req_d     = req_q;
        rdata_d   = o_rdata;
        rvalid_d  = 1'b0;
        ram_we    = 1'b0;
        ram_waddr = 8'h00;
        ram_wdata = 8'h00;
        ram_raddr = 8'h00;
        sfr_we    = 1'b0;
        sfr_addr  = 8'h00;
        sfr_wdata = 8'h00;
        byte_v    = 8'h00;
        from_ram  = 1'b0;
        bank      = {status_q[BANK_HIGH_POS], status_q[BANK_LOW_POS]}; // RULE14
        top_inc   = top_q + 8'd1;
        take      = i_req.valid && o_ready;
        result_d  = result_q;
        second_d  = second_q;
        top_d     = top_q;
        phigh_d   = phigh_q;
        plow_d    = plow_q;
        status_d  = status_q;

        // Core datapath updates; a request in the same cycle overrides.
        if (i_alu.result_we) result_d = i_alu.result;
        if (i_alu.second_we) begin
            second_d = i_alu.second; // RULE11
        end
        if (i_alu.carry_we)   status_d[CARRY_POS]   = i_alu.carry;
        if (i_alu.half_we)    status_d[HALF_POS]    = i_alu.half;
        if (i_alu.overrun_we) status_d[OVERRUN_POS] = i_alu.overrun;
        ptr_v = {phigh_q, plow_q};
        if (i_alu.ptr_we) begin
            ptr_v = i_alu.ptr; // RULE12
        end else if (i_alu.ptr_inc) begin
            ptr_v = ptr_v + 16'h0001; // RULE12
        end
        {phigh_d, plow_d} = ptr_v;

        case (state_q)
            S_IDLE: begin
                if (take) begin
                    req_d    = i_req;
                    rvalid_d = 1'b1;
                    case (i_req.kind)
                        K_DIRECT_WR: begin
                            if (i_req.addr < SPECIAL_BASE) begin
                                ram_we    = 1'b1; // RULE5
                                ram_waddr = i_req.addr;
                                ram_wdata = i_req.wdata;
                            end else begin
                                sfr_we    = 1'b1; // RULE4
                                sfr_addr  = i_req.addr;
                                sfr_wdata = i_req.wdata;
                            end
                        end
                        K_INDIRECT_WR: begin
                            ram_we    = 1'b1; // RULE5
                            ram_waddr = i_req.addr;
                            ram_wdata = i_req.wdata;
                        end
                        K_REG_WR: begin
                            ram_we    = 1'b1; // RULE7
                            ram_waddr = reg_byte(bank, i_req.addr[2:0]);
                            ram_wdata = i_req.wdata;
                        end
                        K_PUSH: begin
                            top_d     = top_inc; // RULE10
                            ram_we    = 1'b1; // RULE9
                            ram_waddr = top_inc;
                            ram_wdata = i_req.wdata;
                        end
                        K_BIT_WR: begin
                            if (i_req.addr[7]) begin
                                sfr_addr  = bit_byte(i_req.addr); // RULE13
                                byte_v    = sfr_read(sfr_addr, result_q, second_q, top_q,
                                                     phigh_q, plow_q, status_q);
                                byte_v[i_req.addr[2:0]] = i_req.wdata[0];
                                sfr_we    = 1'b1;
                                sfr_wdata = byte_v;
                            end else begin
                                ram_raddr = bit_byte(i_req.addr); // RULE8
                                rvalid_d  = 1'b0;
                                state_d   = S_READ;
                            end
                        end
                        default: begin
                            rvalid_d = 1'b0;
                            state_d  = S_READ;
                            case (i_req.kind)
                                K_REG_RD: ram_raddr = reg_byte(bank, i_req.addr[2:0]); // RULE7
                                K_POP:    ram_raddr = top_q; // RULE9
                                K_BIT_RD: ram_raddr = bit_byte(i_req.addr); // RULE8
                                default:  ram_raddr = i_req.addr; // RULE5
                            endcase
                        end
                    endcase
                end
            end
            S_READ: begin
                state_d  = S_IDLE;
                rvalid_d = 1'b1;
                case (req_q.kind)
                    K_DIRECT_RD: from_ram = !req_q.addr[7]; // RULE5
                    K_BIT_RD:    from_ram = !req_q.addr[7];
                    K_BIT_WR:    from_ram = 1'b1;
                    default:     from_ram = 1'b1;
                endcase
                if (from_ram) begin
                    byte_v = ram_rdata;
                end else begin
                    byte_v = sfr_read(bit_byte(req_q.addr) | {8{req_q.kind != K_BIT_RD}}
                                      & req_q.addr, result_q, second_q, top_q,
                                      phigh_q, plow_q, status_q);
                end
                rdata_d = byte_v;
                if (req_q.kind == K_BIT_RD) begin
                    rdata_d = {7'h00, byte_v[req_q.addr[2:0]]}; // RULE8
                end
                if (req_q.kind == K_BIT_WR) begin
                    byte_v[req_q.addr[2:0]] = req_q.wdata[0];
                    ram_we    = 1'b1; // RULE8
                    ram_waddr = bit_byte(req_q.addr);
                    ram_wdata = byte_v;
                    rdata_d   = o_rdata;
                end
                if (req_q.kind == K_POP) begin
                    top_d = top_q - 8'd1; // RULE9
                end
            end
            default: state_d = S_IDLE;
        endcase

        if (sfr_we) begin
            case (sfr_addr)
                SFR_RESULT:    result_d = sfr_wdata;
                SFR_SECOND:    second_d = sfr_wdata; // RULE11
                SFR_STACK_TOP: top_d    = sfr_wdata;
                SFR_DATA_HIGH: phigh_d  = sfr_wdata; // RULE12
                SFR_DATA_LOW:  plow_d   = sfr_wdata; // RULE12
                SFR_STATUS:    status_d = sfr_wdata[7:1]; // RULE15
                default:       ; // RULE6
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q    <= S_IDLE;
            req_q      <= '0;
            result_q   <= REG_RST;
            second_q   <= REG_RST;
            top_q      <= STACK_TOP_RST; // RULE10
            phigh_q    <= REG_RST;
            plow_q     <= REG_RST;
            status_q   <= STATUS_RST[7:1]; // RULE13
            o_ready    <= 1'b0;
            o_rvalid   <= 1'b0;
            o_rdata    <= 8'h00;
            o_view     <= '{stack_top: STACK_TOP_RST, status: STATUS_RST, default: REG_RST};
            o_code_ptr <= '0;
        end else begin
            state_q    <= state_d;
            req_q      <= req_d;
            result_q   <= result_d;
            second_q   <= second_d;
            top_q      <= top_d;
            phigh_q    <= phigh_d;
            plow_q     <= plow_d;
            status_q   <= status_d;
            o_ready    <= (state_d == S_IDLE);
            o_rvalid   <= rvalid_d;
            o_rdata    <= rdata_d;
            o_view     <= '{result: result_d, second: second_d, stack_top: top_d,
                            ptr_high: phigh_d, ptr_low: plow_d,
                            status: {status_d, ^result_d}}; // RULE15
            o_code_ptr <= {phigh_d[4:0], plow_d}; // RULE3
        end
    end
endmodule : cpu_data_memory_map
`default_nettype wire

/* File: testbench/cpu_data_memory_map_monitor.sv */
/*
 * Checker for the data-memory map block, watching only its top ports.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module cpu_data_memory_map_monitor (
    input wire logic                            i_clk,
    input wire logic                            i_rst,
    input wire logic [data_map_pkg::DIV_SEL_W-1:0] i_div_sel,
    input wire data_map_pkg::mem_req_s          i_req,
    input wire data_map_pkg::alu_upd_s          i_alu,
    input wire logic                            o_ready,
    input wire logic                            o_rvalid,
    input wire logic [7:0]                      o_rdata,
    input wire data_map_pkg::core_view_s        o_view,
    input wire logic [data_map_pkg::CODE_ADDR_W-1:0] o_code_ptr,
    input wire logic                            o_core_tick,
    input wire logic                            o_machine_tick
);
    import data_map_pkg::*;
    // ==============================================================
    // Helper logic
    // ==============================================================
    // Core ticks are counted per machine tick; the first interval after
    // reset is skipped because its phase is not defined.
    logic       take;
    logic [4:0] cnt_d, cnt_q;
    logic       armed_d, armed_q;
    assign take = i_req.valid && o_ready;
    always_comb begin
        cnt_d   = o_machine_tick ? 5'h00 : cnt_q + {4'h0, o_core_tick};
        armed_d = armed_q | o_machine_tick;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q   <= 5'h00;
            armed_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            armed_q <= armed_d;
        end
    end
    // ==============================================================
    // Assertions
    // ==============================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_SP_RESET: assert property ($past(i_rst) |-> o_view.stack_top == 8'h07)
        else $error("stack pointer not 07 after reset");
    AST_STATUS_RESET: assert property ($past(i_rst) |-> o_view.status == 8'h00)
        else $error("status word not 00 after reset");
    AST_PUSH_INC: assert property (take && i_req.kind == K_PUSH |=>
        o_rvalid && o_view.stack_top == $past(o_view.stack_top) + 8'h01)
        else $error("push did not pre-increment stack pointer");
    AST_POP_DEC: assert property (take && i_req.kind == K_POP |-> ##2
        (o_rvalid && o_view.stack_top == $past(o_view.stack_top, 2) - 8'h01))
        else $error("pop did not decrement stack pointer");
    AST_READ_LAT: assert property (take && (i_req.kind == K_DIRECT_RD ||
        i_req.kind == K_INDIRECT_RD) |=> !o_ready && !o_rvalid ##1 o_rvalid && o_ready)
        else $error("read answer timing wrong");
    AST_PARITY: assert property (o_view.status[0] == ^o_view.result)
        else $error("parity bit does not follow result");
    AST_MACHINE: assert property (o_machine_tick && armed_q |->
        cnt_q + {4'h0, o_core_tick} == 5'h0c)
        else $error("machine cycle is not twelve core ticks");
    AST_CORE_PULSE: assert property (o_core_tick |=> !o_core_tick)
        else $error("core tick faster than the pll rate allows");
    AST_CODE_PTR: assert property (o_code_ptr == {o_view.ptr_high[4:0], o_view.ptr_low})
        else $error("code pointer does not match pointer pair");
    AST_PTR_LOAD: assert property (i_alu.ptr_we && !i_req.valid |=>
        {o_view.ptr_high, o_view.ptr_low} == $past(i_alu.ptr))
        else $error("16-bit pointer load lost");
endmodule : cpu_data_memory_map_monitor
`default_nettype wire

/* File: testbench/tb_cpu_data_memory_map.sv */
/*
 * Self-checking bench for the data-memory map block, driven at falling edges.
 * Assumes the package constants and the request contract of the block.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_data_memory_map;
    import data_map_pkg::*;
    logic                   i_clk = 1'b0;
    logic                   i_rst, o_ready, o_rvalid, o_core_tick, o_machine_tick;
    logic [DIV_SEL_W-1:0]   i_div_sel;
    mem_req_s               i_req;
    alu_upd_s               i_alu;
    logic [7:0]             o_rdata, q;
    core_view_s             o_view;
    logic [CODE_ADDR_W-1:0] o_code_ptr;
    int                     errors, total_checks, nc, nm, lo;
    always #10 i_clk = ~i_clk;
    cpu_data_memory_map u_cpu_data_memory_map (.i_clk(i_clk), .i_rst(i_rst),
        .i_div_sel(i_div_sel), .i_req(i_req), .i_alu(i_alu), .o_ready(o_ready),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_view(o_view), .o_code_ptr(o_code_ptr),
        .o_core_tick(o_core_tick), .o_machine_tick(o_machine_tick));
    // ==============================================================
    // Tasks
    // ==============================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Request is held from one falling edge across the taking rising edge.
    task automatic acc(input req_kind_e k, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] rd);
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        i_req = '{1'b1, k, a, d};
        @(negedge i_clk);
        i_req.valid = 1'b0;
        n = 0;
        while (o_rvalid !== 1'b1 && n < 4) begin
            @(negedge i_clk);
            n++;
        end
        check({7'h00, o_rvalid}, 8'h01);
        rd = o_rdata;
    endtask : acc
    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // ==============================================================
    // Tests
    // ==============================================================
    initial begin
        #(20 * 20000);
        errors++;
        finish_test();
    end
    initial begin
        i_rst = 1'b1;
        i_div_sel = '0;
        i_req = '0;
        i_alu = '0;
        errors = 0;
        total_checks = 0;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check(o_view.stack_top, 8'h07);
        check(o_view.status, 8'h00);
        acc(K_DIRECT_RD, SFR_STACK_TOP, 8'h00, q);
        check(q, 8'h07);
        acc(K_PUSH, 8'h00, 8'h5a, q);
        check(o_view.stack_top, 8'h08);
        acc(K_DIRECT_RD, 8'h08, 8'h00, q);
        check(q, 8'h5a);
        acc(K_POP, 8'h00, 8'h00, q);
        check(q, 8'h5a);
        check(o_view.stack_top, 8'h07);
        for (int b = 0; b < 4; b++) begin
            acc(K_DIRECT_WR, SFR_STATUS, {3'h0, b[1:0], 3'h0}, q);
            acc(K_REG_WR, {5'h00, 3'(7 - b)}, 8'h40 + 8'(b), q);
            acc(K_DIRECT_RD, {3'h0, b[1:0], 3'(7 - b)}, 8'h00, q);
            check(q, 8'h40 + 8'(b));
            check(o_view.status, {3'h0, b[1:0], 3'h0});
        end
        acc(K_DIRECT_WR, 8'h21, 8'h00, q);
        acc(K_BIT_WR, 8'h0b, 8'h01, q);
        acc(K_DIRECT_RD, 8'h21, 8'h00, q);
        check(q, 8'h08);
        acc(K_BIT_RD, 8'h0b, 8'h00, q);
        check({7'h00, q[0]}, 8'h01);
        acc(K_BIT_WR, 8'hd5, 8'h01, q);
        acc(K_INDIRECT_WR, 8'hd0, 8'ha5, q);
        acc(K_DIRECT_RD, SFR_STATUS, 8'h00, q);
        check(q, 8'h38);
        acc(K_INDIRECT_RD, 8'hd0, 8'h00, q);
        check(q, 8'ha5);
        acc(K_INDIRECT_RD, 8'h08, 8'h00, q);
        check(q, 8'h5a);
        acc(K_DIRECT_RD, 8'h87, 8'h00, q);
        check(q, UNMAPPED_READ);
        acc(K_DIRECT_WR, SFR_RESULT, 8'h07, q);
        acc(K_DIRECT_WR, SFR_STATUS, 8'h00, q);
        acc(K_DIRECT_RD, SFR_STATUS, 8'h00, q);
        check(q, 8'h01);
        acc(K_DIRECT_WR, SFR_SECOND, 8'h3c, q);
        acc(K_DIRECT_RD, SFR_SECOND, 8'h00, q);
        check(q, 8'h3c);
        i_alu.ptr_we = 1'b1;
        i_alu.ptr = 16'h12ff;
        i_alu.carry_we = 1'b1;
        i_alu.carry = 1'b1;
        @(negedge i_clk);
        i_alu.ptr_we = 1'b0;
        i_alu.carry_we = 1'b0;
        i_alu.ptr_inc = 1'b1;
        @(negedge i_clk);
        i_alu.ptr_inc = 1'b0;
        @(negedge i_clk);
        check(o_view.ptr_high, 8'h13);
        check(o_view.ptr_low, 8'h00);
        check({3'h0, o_code_ptr[12:8]}, 8'h13);
        check(o_view.status, 8'h81);
        acc(K_DIRECT_WR, SFR_DATA_LOW, 8'hff, q);
        acc(K_DIRECT_RD, SFR_DATA_HIGH, 8'h00, q);
        check(q, 8'h13);
        check(o_view.ptr_low, 8'hff);
        for (int s = 0; s < 3; s++) begin
            i_div_sel = DIV_SEL_W'(s);
            repeat (30) @(negedge i_clk);
            nc = 0;
            nm = 0;
            repeat (2400) begin
                @(negedge i_clk);
                nc += int'(o_core_tick);
                nm += int'(o_machine_tick);
            end
            lo = 805 >> s;
            check({7'h00, nc >= lo - (2 ** s) - 2 && nc <= lo + (2 ** s) + 2}, 8'h01);
            check({7'h00, nm * 12 >= nc - 24 && nm * 12 <= nc + 24}, 8'h01);
        end
        finish_test();
    end
endmodule : tb_cpu_data_memory_map
bind cpu_data_memory_map cpu_data_memory_map_monitor u_cpu_data_memory_map_monitor (
    .i_clk(i_clk), .i_rst(i_rst), .i_div_sel(i_div_sel), .i_req(i_req), .i_alu(i_alu),
    .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_view(o_view),
    .o_code_ptr(o_code_ptr), .o_core_tick(o_core_tick), .o_machine_tick(o_machine_tick));
`default_nettype wire
